// ===== verilog/analog_ref_amp_control.sv
// top: register port, two amplifiers, reference ladder and pin overrides
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module analog_ref_amp_control (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port
  input wire logic [analog_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic [analog_ctl_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [analog_ctl_pkg::DATA_W-1:0] rdata,
  // digital port pins of the two amplifier outputs and two reference outputs
  input wire logic [3:0] pin_in,
  input wire logic [3:0] port_drive,
  input wire logic [3:0] port_out_en,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [3:0] pin_in_detect_en,
  // analog switch controls
  output analog_ctl_pkg::amp_ctl_s amp1_ctl,
  output analog_ctl_pkg::amp_ctl_s amp2_ctl,
  output analog_ctl_pkg::ref_ctl_s ref_ctl
);
  import analog_ctl_pkg::*;

  logic [7:0] amp1_rd;
  logic [7:0] amp2_rd;
  logic [7:0] ref_rd;
  logic [7:0] lvl_rd;
  logic [3:0] analog_own;
  logic [3:0] digital_in_mask;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  amp_channel u_amp1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(wr_stb && addr == OFS_OPAMP1_CONTROL),
    .wr_data(wdata),
    .ctl_rdata(amp1_rd),
    .ctl(amp1_ctl)
  );

  amp_channel u_amp2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(wr_stb && addr == OFS_OPAMP2_CONTROL),
    .wr_data(wdata),
    .ctl_rdata(amp2_rd),
    .ctl(amp2_ctl)
  );

  ref_ladder_ctl u_ref (
    .mclk(mclk),
    .rst_b(rst_b),
    .ctl_wr(wr_stb && addr == OFS_REF_DAC_CONTROL),
    .lvl_wr(wr_stb && addr == OFS_REF_DAC_LEVEL),
    .wr_data(wdata),
    .ctl_rdata(ref_rd),
    .lvl_rdata(lvl_rd),
    .ctl(ref_ctl)
  );

  // pins 0,1: amplifier outputs; pins 2,3: reference outputs
  assign analog_own = {ref_ctl.out2, ref_ctl.out1, amp2_ctl.pin_driver_off, amp1_ctl.pin_driver_off};

  assign pin_oe = port_out_en & ~analog_own;
  assign pin_out = port_drive & ~analog_own;
  // amplifier pins keep their input detector; only reference pins lose it
  assign digital_in_mask = {~ref_ctl.out2, ~ref_ctl.out1, 2'b11};
  assign pin_in_detect_en = digital_in_mask;

  // pins are asynchronous: a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (addr)
      OFS_OPAMP1_CONTROL: rdata_d = amp1_rd;
      OFS_OPAMP2_CONTROL: rdata_d = amp2_rd;
      OFS_REF_DAC_CONTROL: rdata_d = ref_rd;
      OFS_REF_DAC_LEVEL: rdata_d = lvl_rd;
      OFS_STATUS: rdata_d = {4'h0, analog_own};
      OFS_PORT_READ: rdata_d = {4'h0, pin_q & digital_in_mask};
      default: rdata_d = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd_stb) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;

endmodule

// ===== verilog/analog_ctl_pkg.sv
// package: register map, field layout and carrier types for the amplifier and reference controls
package analog_ctl_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register indices, one byte each on the plain port
  localparam logic [3:0] OFS_OPAMP1_CONTROL = 4'h0;
  localparam logic [3:0] OFS_OPAMP2_CONTROL = 4'h1;
  localparam logic [3:0] OFS_REF_DAC_CONTROL = 4'h2;
  localparam logic [3:0] OFS_REF_DAC_LEVEL = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_PORT_READ = 4'h5;

  // amplifier control fields
  localparam int AMP_EN_BIT = 7;
  localparam int AMP_SP_BIT = 6;
  localparam int AMP_CH_LSB = 0;
  localparam logic [7:0] AMP_IMPL_MASK = 8'hc3;

  // reference control fields
  localparam int REF_EN_BIT = 7;
  localparam int REF_OE1_BIT = 5;
  localparam int REF_OE2_BIT = 4;
  localparam int REF_PSS_LSB = 2;
  localparam int REF_NSS_BIT = 0;
  localparam logic [7:0] REF_IMPL_MASK = 8'hbd;

  localparam logic [7:0] CTL_RESET = 8'h00;

  // amplifier non-inverting input source
  typedef enum logic [1:0] {
    AMP_IN_PIN = 2'b00,
    AMP_IN_PIN_ALT = 2'b01,
    AMP_IN_DAC = 2'b10,
    AMP_IN_FIXED_REF = 2'b11
  } amp_in_e;

  // ladder high source
  typedef enum logic [1:0] {
    HI_SUPPLY = 2'b00,
    HI_REF_PIN = 2'b01,
    HI_FIXED_REF = 2'b10,
    HI_RESERVED = 2'b11
  } ref_hi_e;

  // controls of one amplifier toward the analog switches
  typedef struct packed {
    logic enable;
    logic high_speed;
    logic sel_pin;
    logic sel_dac;
    logic sel_fixed_ref;
    logic pin_driver_off;
  } amp_ctl_s;

  // controls of the reference ladder toward the analog switches
  typedef struct packed {
    logic enable;
    logic hi_supply;
    logic hi_ref_pin;
    logic hi_fixed_ref;
    logic lo_ref_pin;
    logic [7:0] tap;
    logic out1;
    logic out2;
    logic to_comparator;
    logic to_adc;
  } ref_ctl_s;

  // decode one amplifier control byte to switch drives
  function automatic amp_ctl_s amp_decode(input logic [7:0] r);
    amp_ctl_s c;
    amp_in_e s;
    s = amp_in_e'(r[AMP_CH_LSB +: 2]);
    c.enable = r[AMP_EN_BIT];
    c.high_speed = r[AMP_EN_BIT] & r[AMP_SP_BIT];
    c.sel_pin = r[AMP_EN_BIT] & ~s[1];
    c.sel_dac = r[AMP_EN_BIT] & (s == AMP_IN_DAC);
    c.sel_fixed_ref = r[AMP_EN_BIT] & (s == AMP_IN_FIXED_REF);
    c.pin_driver_off = r[AMP_EN_BIT];
    return c;
  endfunction

endpackage

// ===== verilog/amp_channel.sv
// one amplifier: control register, read-back and pin/switch drives
`timescale 1ns/1ps
module amp_channel (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // state
  output logic [7:0] ctl_rdata,
  output analog_ctl_pkg::amp_ctl_s ctl
);
  import analog_ctl_pkg::*;

  logic [7:0] ctl_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= CTL_RESET;
    end else if (wr_en) begin
      ctl_q <= wr_data & AMP_IMPL_MASK;
    end
  end

  assign ctl_rdata = ctl_q & AMP_IMPL_MASK;
  assign ctl = amp_decode(ctl_q);

endmodule

// ===== verilog/ref_ladder_ctl.sv
// reference ladder: control and level registers with their switch drives
`timescale 1ns/1ps
module ref_ladder_ctl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register writes
  input wire logic ctl_wr,
  input wire logic lvl_wr,
  input wire logic [7:0] wr_data,
  // state
  output logic [7:0] ctl_rdata,
  output logic [7:0] lvl_rdata,
  output analog_ctl_pkg::ref_ctl_s ctl
);
  import analog_ctl_pkg::*;

  logic [7:0] ctl_q;
  logic [7:0] lvl_q;
  ref_hi_e hi;

  // no sleep input exists here: state simply holds across any low-power period
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= CTL_RESET;
    end else if (ctl_wr) begin
      ctl_q <= wr_data & REF_IMPL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_q <= CTL_RESET;
    end else if (lvl_wr) begin
      lvl_q <= wr_data;
    end
  end

  assign ctl_rdata = ctl_q & REF_IMPL_MASK;
  assign lvl_rdata = lvl_q;
  assign hi = ref_hi_e'(ctl_q[REF_PSS_LSB +: 2]);

  always_comb begin
    ctl.enable = ctl_q[REF_EN_BIT];
    // reserved high-source code opens every high switch rather than shorting sources
    ctl.hi_supply = ctl_q[REF_EN_BIT] & (hi == HI_SUPPLY);
    ctl.hi_ref_pin = ctl_q[REF_EN_BIT] & (hi == HI_REF_PIN);
    ctl.hi_fixed_ref = ctl_q[REF_EN_BIT] & (hi == HI_FIXED_REF);
    ctl.lo_ref_pin = ctl_q[REF_NSS_BIT];
    ctl.tap = lvl_q;
    ctl.out1 = ctl_q[REF_EN_BIT] & ctl_q[REF_OE1_BIT];
    ctl.out2 = ctl_q[REF_EN_BIT] & ctl_q[REF_OE2_BIT];
    ctl.to_comparator = ctl_q[REF_EN_BIT];
    ctl.to_adc = ctl_q[REF_EN_BIT];
  end

endmodule

// ===== test/analog_ctl_properties.sv
// checker: port-level properties of the amplifier and reference control block
`timescale 1ns/1ps
module analog_ctl_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  // pins
  input wire logic [3:0] pin_in,
  input wire logic [3:0] port_drive,
  input wire logic [3:0] port_out_en,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_in_detect_en,
  // switch controls
  input wire analog_ctl_pkg::amp_ctl_s amp1_ctl,
  input wire analog_ctl_pkg::amp_ctl_s amp2_ctl,
  input wire analog_ctl_pkg::ref_ctl_s ref_ctl
);
  import analog_ctl_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  amp_enable_a: assert property (wr_stb && addr == 4'h0 |=> amp1_ctl.enable == $past(wdata[7]))
    else $error("amp1 enable wrong");
  amp_speed_a: assert property (wr_stb && addr == 4'h1 |=> amp2_ctl.high_speed == &$past(wdata[7:6]))
    else $error("amp2 speed wrong");
  amp_dac_a: assert property (wr_stb && addr == 4'h0 && wdata[7] |=>
    amp1_ctl.sel_dac == ($past(wdata[1:0]) == 2'h2))
    else $error("amp1 input select wrong");
  amp_pin_a: assert property (pin_oe[1:0] == (port_out_en[1:0] & ~{amp2_ctl.enable, amp1_ctl.enable}))
    else $error("amp pin driver not released");
  rd_unimpl_a: assert property (rd_stb && addr < 4'h3 |=>
    (rdata & ($past(addr) == 4'h2 ? 8'h42 : 8'h3c)) == 8'h00)
    else $error("unimplemented bits read nonzero");
  rd_idle_a: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  port_mask_a: assert property (rd_stb && addr == 4'h5 && ref_ctl.out1 |=> !rdata[2])
    else $error("reference pin read not zero");
  ref_out_a: assert property (wr_stb && addr == 4'h2 |=> ref_ctl.out1 == &$past({wdata[7], wdata[5]}))
    else $error("reference output one wrong");
  ref_pin_a: assert property (
    pin_in_detect_en[3:2] == ~{ref_ctl.out2, ref_ctl.out1} && !(ref_ctl.out1 && pin_oe[2]))
    else $error("reference pin not overridden");
  ref_tap_a: assert property (wr_stb && addr == 4'h3 |=> ref_ctl.tap == $past(wdata))
    else $error("level code wrong");
  rst_clear_a: assert property ($rose(rst_b) |-> {amp1_ctl, amp2_ctl} == 12'h000 && ref_ctl == 17'h0)
    else $error("controls not cleared by reset");
  cover property (wr_stb && addr == 4'h2 && wdata[7]);
  cover property (rd_stb && addr == 4'h5);
  cover property (amp2_ctl.sel_fixed_ref);
endmodule
bind analog_ref_amp_control analog_ctl_properties analog_ctl_properties_inst (.mclk, .rst_b, .addr, .wdata,
  .wr_stb, .rd_stb, .rdata, .pin_in, .port_drive, .port_out_en, .pin_out, .pin_oe, .pin_in_detect_en,
  .amp1_ctl, .amp2_ctl, .ref_ctl);

// ===== test/cpu_port_model.sv
// partner: core-side master of the plain register port
`timescale 1ns/1ps
module cpu_port_model (
  // clock
  input wire logic mclk,
  // register port
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // returns once the write has landed, so callers may look at the controls at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
endmodule

// ===== test/analog_ref_amp_control_tb_top.sv
// testbench: reset, amplifier, reference and unmapped-access scenarios
`timescale 1ns/1ps
module analog_ref_amp_control_tb_top;
  import analog_ctl_pkg::*;
  logic mclk, rst_b, wr_stb, rd_stb;
  logic [3:0] addr, pin_in, port_drive, port_out_en, pin_out, pin_oe, pin_in_detect_en;
  logic [7:0] wdata, rdata, rv;
  amp_ctl_s amp1_ctl, amp2_ctl;
  ref_ctl_s ref_ctl;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  analog_ref_amp_control analog_ref_amp_control_inst (.mclk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .pin_in, .port_drive, .port_out_en, .pin_out, .pin_oe, .pin_in_detect_en, .amp1_ctl, .amp2_ctl, .ref_ctl);
  cpu_port_model cpu (.mclk, .addr, .wdata, .wr_stb, .rd_stb, .rdata);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // a hang costs at most a few thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      conclude;
    end
  end
  task automatic t_reset;
    for (int r = 0; r < 4; r++) begin
      cpu.rd(4'(r), rv);
      chk("reg reset", 17'(rv), 17'h0);
    end
    chk("ctl reset", {amp1_ctl, amp2_ctl, ref_ctl[16:12]}, 17'h0);
    chk("pin reset", 17'({pin_out, pin_oe, pin_in_detect_en}), 17'haff);
  endtask
  task automatic t_amp;
    for (int i = 0; i < 2; i++) begin
      for (int s = 0; s < 4; s++) begin
        cpu.wr(4'(i), 8'hfc | 8'(s));
        cpu.rd(4'(i), rv);
        chk("amp read", 17'(rv), 17'(8'hc0 | 8'(s)));
        chk("amp ctl", 17'(i ? amp2_ctl : amp1_ctl), 17'({2'h3, s < 2, s == 2, s == 3, 1'b1}));
        chk("amp pin", 17'(pin_oe[1:0]), 17'(i ? 2'b01 : 2'b10));
        cpu.wr(4'(i), 8'h81);
        chk("amp slow", 17'(i ? amp2_ctl : amp1_ctl), 17'h29);
      end
      cpu.wr(4'(i), 8'h40);
      chk("amp off", 17'(i ? amp2_ctl : amp1_ctl), 17'h0);
    end
  endtask
  task automatic t_ref;
    logic [7:0] lv[3] = '{8'h00, 8'h80, 8'hff};
    cpu.wr(4'h2, 8'hff);
    cpu.rd(4'h2, rv);
    chk("ref read", 17'(rv), 17'h0bd);
    // reserved high source opens every high switch
    chk("ref ctl", ref_ctl, {5'b10001, 8'h00, 4'hf});
    chk("ref pins", 17'({pin_out, pin_oe, pin_in_detect_en}), 17'h233);
    repeat (4) @(posedge mclk);
    cpu.rd(4'h5, rv);
    chk("port read", 17'(rv[3:0]), 17'h3);
    for (int p = 0; p < 3; p++) begin
      cpu.wr(4'h2, 8'h80 | 8'(p << 2));
      chk("high src", 17'(ref_ctl[16:12]), 17'({1'b1, p == 0, p == 1, p == 2, 1'b0}));
    end
    cpu.wr(4'h2, 8'h01);
    chk("ref off", ref_ctl, 17'h01000);
    // pin levels cross four flops, so a read two edges later still shows the old level
    @(posedge mclk);
    pin_in <= 4'h6;
    cpu.rd(4'h5, rv);
    chk("pin sync", 17'(rv[3:0]), 17'hf);
    repeat (3) @(posedge mclk);
    cpu.rd(4'h5, rv);
    chk("pin read", 17'(rv[3:0]), 17'h6);
    foreach (lv[k]) begin
      cpu.wr(4'h3, lv[k]);
      cpu.rd(4'h3, rv);
      chk("level", 17'({ref_ctl.tap, rv}), 17'({lv[k], lv[k]}));
    end
  endtask
  task automatic t_midreset;
    cpu.wr(4'h4, 8'hff);
    cpu.wr(4'h9, 8'hff);
    cpu.rd(4'hf, rv);
    chk("unmapped", 17'(rv), 17'h0);
    cpu.wr(4'h0, 8'hc3);
    cpu.wr(4'h2, 8'hb0);
    cpu.rd(4'h4, rv);
    chk("status", 17'(rv), 17'h0d);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
  endtask
  initial begin
    rst_b = 1'b0;
    pin_in = 4'hf;
    port_drive = 4'ha;
    port_out_en = 4'hf;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_amp();
    t_ref();
    t_midreset();
    conclude;
  end
endmodule
